/* hdl/fwbp_top.sv */
// fetch window branch predictor: window table, return stack, prediction port
// assumes fetch and resolve inputs are synchronous to CORE_CLK
//
// Contract
// - at most three near branches kept per aligned 16-byte window
// - branch window chosen by its last byte, so straddlers go later
// - taken prediction of a window-straddling branch dispatches alone
// - only branches resolved taken are allocated; a stored branch counts up when taken, down when not
// - more than three taken branches per window lose stored predictions
// - short one-byte return may go unpredicted in some placements
// - short return reached as a branch target is marked unpredictable
// - short return falling through from a conditional branch unpredictable
// - padded return with zero pop count predicted as a normal return
// - a non-branch between conditional and short return clears the hazard
// - next fetch delivers target onward to end of 32-byte block
// - far transfers are never predicted
// - calls push next address; overflow drops the oldest entry
// - zero-displacement call leaves the return stack untouched
// - predicted taken costs one fetch bubble; not taken costs none
`timescale 1ns/1ns
`default_nettype none

module fwbp_top #(
	parameter int SET_BITS = 6,
	parameter int RAS_DEPTH = 8
) (
	input wire logic CORE_CLK,
	input wire logic NRST,
	input wire logic FETCH_VALID,
	input wire logic [fwbp_pkg::ADDR_W-1:0] FETCH_ADDR,
	input wire logic RES_VALID,
	input wire fwbp_pkg::fwbp_resolve_type RES,
	output fwbp_pkg::fwbp_pred_type PRED,
	output logic FETCH_STALL
);
	import fwbp_pkg::*;

	localparam int NSETS = 1 << SET_BITS;
	localparam int RP_W = $clog2(RAS_DEPTH);
	localparam logic [RP_W:0] RAS_FULL = (RP_W+1)'(RAS_DEPTH);
	localparam logic [RP_W:0] RAS_EMPTY = '0;

	// ***********************************************
	// helpers
	// ***********************************************
	function automatic logic [WIN_W-1:0] win_of(input logic [ADDR_W-1:0] a);
		win_of = a[ADDR_W-1:WIN_BITS];
	endfunction

	function automatic logic [SET_BITS-1:0] set_of(input logic [ADDR_W-1:0] a);
		set_of = a[WIN_BITS+SET_BITS-1:WIN_BITS];
	endfunction

	// ***********************************************
	// reset release
	// ***********************************************
	logic rst_meta_reg;
	logic rst_n_reg;

	// async assert, release through two flops
	always_ff @(posedge CORE_CLK or negedge NRST) begin
		if (!NRST) begin
			rst_meta_reg <= 1'b0;
			rst_n_reg <= 1'b0;
		end else begin
			rst_meta_reg <= 1'b1;
			rst_n_reg <= rst_meta_reg;
		end
	end

	// ***********************************************
	// storage
	// ***********************************************
	fwbp_entry_type tbl_reg [NSETS][WAYS];
	logic [ADDR_W-1:0] ras_reg [RAS_DEPTH];
	logic [RP_W-1:0] ras_top_reg;
	logic [RP_W:0] ras_cnt_reg;
	logic bubble_reg;

	// ***********************************************
	// lookup
	// ***********************************************
	logic fetch_take;
	logic [WIN_W-1:0] f_win;
	logic [SET_BITS-1:0] f_set;
	logic [WIN_BITS-1:0] f_off;
	logic f_found;
	fwbp_entry_type f_ent;
	logic f_hit;
	logic f_taken;
	logic [ADDR_W-1:0] f_target;
	fwbp_pred_type pred_next;

	// a bubble cycle ignores fetch, that is the cost of a taken prediction
	assign fetch_take = FETCH_VALID && !bubble_reg;

	// nearest stored branch ending at or after the fetch offset
	always_comb begin
		f_win = win_of(FETCH_ADDR);
		f_set = set_of(FETCH_ADDR);
		f_off = FETCH_ADDR[WIN_BITS-1:0];
		f_found = 1'b0;
		f_ent = '0;
		for (int w = 0; w < WAYS; w++) begin
			if (tbl_reg[f_set][w].valid && tbl_reg[f_set][w].win == f_win &&
			    tbl_reg[f_set][w].end_off >= f_off &&
			    (!f_found || tbl_reg[f_set][w].end_off < f_ent.end_off)) begin
				f_found = 1'b1;
				f_ent = tbl_reg[f_set][w];
			end
		end
	end

	// turn the entry into a direction and target
	always_comb begin
		f_hit = f_found && !f_ent.ret_unpred;
		f_target = f_ent.target;
		f_taken = 1'b0;
		if (f_hit) begin
			case (f_ent.kind)
				BK_COND: f_taken = f_ent.ctr[1];
				BK_RET: begin
					f_taken = ras_cnt_reg != RAS_EMPTY;
					f_target = ras_reg[ras_top_reg];
				end
				BK_JUMP, BK_CALL: f_taken = 1'b1;
				default: f_taken = 1'b0;
			endcase
		end
	end

	// next fetch address and how many bytes it yields
	always_comb begin
		pred_next = '0;
		pred_next.valid = fetch_take;
		pred_next.hit = fetch_take && f_hit;
		pred_next.taken = fetch_take && f_taken;
		pred_next.solo = fetch_take && f_taken && f_ent.split;
		pred_next.end_off = f_ent.end_off;
		pred_next.next_addr = f_taken ? f_target : ((FETCH_ADDR | BLOCK_MASK) + ONE_BYTE);
		pred_next.next_bytes = BLOCK_BYTES - {1'b0, pred_next.next_addr[BLOCK_BITS-1:0]};
	end

	// prediction and stall outputs, all flopped
	always_ff @(posedge CORE_CLK or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			PRED <= '0;
			bubble_reg <= 1'b0;
			FETCH_STALL <= 1'b0;
		end else begin
			PRED <= pred_next;
			bubble_reg <= pred_next.taken;
			FETCH_STALL <= pred_next.taken;
		end
	end

	// ***********************************************
	// resolve and allocate
	// ***********************************************
	logic [WIN_W-1:0] r_win;
	logic [SET_BITS-1:0] r_set;
	logic [WIN_BITS-1:0] r_off;
	logic r_hit;
	int r_way;
	int r_free;
	logic r_alloc;
	fwbp_entry_type r_new;

	// window by last byte; find a matching or free way
	always_comb begin
		r_win = win_of(RES.end_addr);
		r_set = set_of(RES.end_addr);
		r_off = RES.end_addr[WIN_BITS-1:0];
		r_hit = 1'b0;
		r_way = REPLACE_WAY;
		r_free = REPLACE_WAY;
		for (int w = WAYS - 1; w >= 0; w--) begin
			if (!tbl_reg[r_set][w].valid) begin
				r_free = w;
			end
			if (tbl_reg[r_set][w].valid && tbl_reg[r_set][w].win == r_win &&
			    tbl_reg[r_set][w].end_off == r_off) begin
				r_hit = 1'b1;
				r_way = w;
			end
		end
		if (!r_hit) begin
			r_way = r_free;
		end
		// never-taken and far branches take no entry
		r_alloc = RES_VALID && !r_hit && RES.taken && RES.kind != BK_FAR;
		r_new = '0;
		r_new.valid = 1'b1;
		r_new.win = r_win;
		r_new.end_off = r_off;
		r_new.kind = RES.kind;
		r_new.split = win_of(RES.start_addr) != r_win;
		// only the single-byte form is exposed; the padded form always predicts
		r_new.ret_unpred = RES.kind == BK_RET && RES.opcode == SHORT_RET_OPCODE &&
		                   (RES.is_branch_target || RES.after_cond);
		r_new.ctr = CTR_ALLOC;
		r_new.target = RES.target;
	end

	// table update, one write per cycle
	always_ff @(posedge CORE_CLK or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			for (int s = 0; s < NSETS; s++) begin
				for (int w = 0; w < WAYS; w++) begin
					tbl_reg[s][w] <= '0;
				end
			end
		end else if (r_alloc) begin
			tbl_reg[r_set][r_way] <= r_new;
		end else if (RES_VALID && r_hit) begin
			if (RES.taken) begin
				tbl_reg[r_set][r_way].target <= RES.target;
				if (tbl_reg[r_set][r_way].ctr != CTR_MAX) begin
					tbl_reg[r_set][r_way].ctr <= tbl_reg[r_set][r_way].ctr + 2'h1;
				end
			end else if (tbl_reg[r_set][r_way].ctr != CTR_MIN) begin
				tbl_reg[r_set][r_way].ctr <= tbl_reg[r_set][r_way].ctr - 2'h1;
			end
		end
	end

	// ***********************************************
	// return address stack
	// ***********************************************
	logic ras_push;
	logic ras_pop;
	logic [RP_W-1:0] ras_push_ptr;

	// circular stack: a push when full silently overwrites the oldest slot
	assign ras_push = RES_VALID && RES.kind == BK_CALL && !RES.call_disp_zero;
	assign ras_pop = RES_VALID && RES.kind == BK_RET && ras_cnt_reg != RAS_EMPTY;
	assign ras_push_ptr = ras_top_reg + RP_W'(1);

	// stack contents
	always_ff @(posedge CORE_CLK or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			for (int i = 0; i < RAS_DEPTH; i++) begin
				ras_reg[i] <= '0;
			end
		end else if (ras_push) begin
			ras_reg[ras_push_ptr] <= RES.end_addr + ONE_BYTE;
		end
	end

	// pointer and occupancy; empty stack gives no return prediction
	always_ff @(posedge CORE_CLK or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			ras_top_reg <= '0;
			ras_cnt_reg <= RAS_EMPTY;
		end else if (ras_push) begin
			ras_top_reg <= ras_push_ptr;
			if (ras_cnt_reg != RAS_FULL) begin
				ras_cnt_reg <= ras_cnt_reg + (RP_W+1)'(1);
			end
		end else if (ras_pop) begin
			ras_top_reg <= ras_top_reg - RP_W'(1);
			ras_cnt_reg <= ras_cnt_reg - (RP_W+1)'(1);
		end
	end

endmodule

`default_nettype wire

/* inc/fwbp_pkg.sv */
// fetch window branch predictor: shared constants, enums and carrier structs
// assumes a byte-addressed instruction stream and a single core clock
package fwbp_pkg;

	// ***********************************************
	// geometry and encodings
	// ***********************************************
	localparam int ADDR_W = 32;
	localparam int WIN_BITS = 4; // 16-byte prediction window
	localparam int BLOCK_BITS = 5; // 32-byte fetch block
	localparam int WAYS = 3; // branches kept per window
	localparam int REPLACE_WAY = 2; // fixed victim in a full window
	localparam int WIN_W = ADDR_W - WIN_BITS;
	localparam logic [BLOCK_BITS:0] BLOCK_BYTES = 6'h20;
	localparam logic [ADDR_W-1:0] BLOCK_MASK = 32'h0000001f;
	localparam logic [ADDR_W-1:0] ONE_BYTE = 32'h00000001;
	localparam logic [7:0] SHORT_RET_OPCODE = 8'hc3;
	localparam logic [7:0] IMM_RET_OPCODE = 8'hc2;
	localparam logic [1:0] CTR_ALLOC = 2'h2; // weakly taken on first allocation
	localparam logic [1:0] CTR_MAX = 2'h3;
	localparam logic [1:0] CTR_MIN = 2'h0;

	// ***********************************************
	// types
	// ***********************************************
	typedef enum logic [2:0] {
		BK_COND = 3'h0,
		BK_JUMP = 3'h1,
		BK_CALL = 3'h3,
		BK_RET = 3'h2,
		BK_FAR = 3'h6
	} fwbp_kind_type;

	// one resolved branch reported by the execution side
	typedef struct packed {
		logic [ADDR_W-1:0] start_addr;
		logic [ADDR_W-1:0] end_addr;
		logic [ADDR_W-1:0] target;
		fwbp_kind_type kind;
		logic taken;
		logic [7:0] opcode;
		logic [15:0] pop_count_immediate;
		logic call_disp_zero;
		logic is_branch_target;
		logic after_cond;
	} fwbp_resolve_type;

	// one stored branch
	typedef struct packed {
		logic valid;
		logic [WIN_W-1:0] win;
		logic [WIN_BITS-1:0] end_off;
		fwbp_kind_type kind;
		logic split;
		logic ret_unpred;
		logic [1:0] ctr;
		logic [ADDR_W-1:0] target;
	} fwbp_entry_type;

	// prediction handed to fetch and dispatch
	typedef struct packed {
		logic valid;
		logic hit;
		logic taken;
		logic solo;
		logic [WIN_BITS-1:0] end_off;
		logic [ADDR_W-1:0] next_addr;
		logic [BLOCK_BITS:0] next_bytes;
	} fwbp_pred_type;

endpackage

/* sim/fwbp_checker.sv */
// checker: port timing of the fetch window predictor
// assumes it is bound into fwbp_top and sees only its ports
`timescale 1ns/1ns
`default_nettype none
module fwbp_checker #(
	parameter int SET_BITS = 6,
	parameter int RAS_DEPTH = 8
) (
	input wire logic CORE_CLK,
	input wire logic NRST,
	input wire logic FETCH_VALID,
	input wire logic [fwbp_pkg::ADDR_W-1:0] FETCH_ADDR,
	input wire logic RES_VALID,
	input wire fwbp_pkg::fwbp_resolve_type RES,
	input wire fwbp_pkg::fwbp_pred_type PRED,
	input wire logic FETCH_STALL
);
	import fwbp_pkg::*;
	// ****************************
	// properties
	// ****************************
	default clocking cb @(posedge CORE_CLK); endclocking
	default disable iff (!NRST);
	property p_take; FETCH_VALID && !FETCH_STALL |=> PRED.valid; endproperty
	a_take: assert property (p_take) else $error("lookup not answered");
	property p_refuse; FETCH_STALL |=> !PRED.valid; endproperty
	a_refuse: assert property (p_refuse) else $error("lookup taken in bubble");
	// stall is flopped together with the taken prediction and lasts exactly one cycle
	property p_bubble; PRED.valid && PRED.taken |-> FETCH_STALL ##1 !FETCH_STALL; endproperty
	a_bubble: assert property (p_bubble) else $error("no bubble after taken");
	property p_nobub; !(PRED.valid && PRED.taken) |-> !FETCH_STALL; endproperty
	a_nobub: assert property (p_nobub) else $error("bubble without taken");
	property p_solo; PRED.solo |-> PRED.valid && PRED.taken; endproperty
	a_solo: assert property (p_solo) else $error("solo without taken");
	property p_seq; PRED.valid && !PRED.taken |-> PRED.next_addr == (($past(FETCH_ADDR) | BLOCK_MASK) + ONE_BYTE);
	endproperty
	a_seq: assert property (p_seq) else $error("wrong next block");
	property p_bytes; PRED.valid |-> PRED.next_bytes == BLOCK_BYTES - {1'b0, PRED.next_addr[4:0]}; endproperty
	a_bytes: assert property (p_bytes) else $error("wrong byte count");
	property p_hit; PRED.taken |-> PRED.hit && PRED.valid; endproperty
	a_hit: assert property (p_hit) else $error("taken without entry");
	property p_rst; $rose(NRST) |-> !PRED.valid && !FETCH_STALL ##1 !PRED.valid; endproperty
	a_rst: assert property (p_rst) else $error("output after reset");
endmodule
bind fwbp_top fwbp_checker #(.SET_BITS(SET_BITS), .RAS_DEPTH(RAS_DEPTH)) chk (.CORE_CLK(CORE_CLK), .NRST(NRST),
	.FETCH_VALID(FETCH_VALID), .FETCH_ADDR(FETCH_ADDR), .RES_VALID(RES_VALID), .RES(RES), .PRED(PRED),
	.FETCH_STALL(FETCH_STALL));
`default_nettype wire

/* sim/fwbp_fetch_model.sv */
// fetch stage model: holds each lookup until taken outside a bubble
// assumes go stands while the bench has a request ready for the free slot
`timescale 1ns/1ns
`default_nettype none
module fwbp_fetch_model (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic go,
	input wire logic [31:0] addr,
	input wire logic stall,
	output logic fetch_valid,
	output logic [31:0] fetch_addr
);
	logic [31:0] addr_reg;
	// re-present while the bubble refuses
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			fetch_valid <= 1'b0;
			addr_reg <= 32'h0;
		end else if (!fetch_valid || !stall) begin
			// slot free or just accepted: load the next request, back to back if one waits
			fetch_valid <= go;
			if (go) begin
				addr_reg <= addr;
			end
		end
	end
	// idle address shows junk so stale values cannot pass
	assign fetch_addr = fetch_valid ? addr_reg : ~addr_reg;
endmodule
`default_nettype wire

/* sim/testbench.sv */
// bench: window table and return stack model compared at every prediction
// assumes fwbp_top, its checker and the fetch model are compiled first
`timescale 1ns/1ns
`default_nettype none
module testbench;
	import fwbp_pkg::*;
	typedef struct {int off; logic [31:0] tgt; bit solo; bit unp; bit ret;} fwbp_ment_type;
	logic CORE_CLK = 1'b0, NRST = 1'b0, RES_VALID = 1'b0, go = 1'b0, FETCH_VALID, FETCH_STALL;
	logic [31:0] FETCH_ADDR, go_addr = 32'h0, b;
	fwbp_resolve_type RES = '0;
	fwbp_pred_type PRED;
	int fails = 0, samples_checked = 0;
	fwbp_ment_type tbl[int][$];
	logic [31:0] ras[$];
	fwbp_top #(.SET_BITS(6), .RAS_DEPTH(8)) uut (.CORE_CLK(CORE_CLK), .NRST(NRST), .FETCH_VALID(FETCH_VALID),
		.FETCH_ADDR(FETCH_ADDR), .RES_VALID(RES_VALID), .RES(RES), .PRED(PRED), .FETCH_STALL(FETCH_STALL));
	fwbp_fetch_model fm (.clk(CORE_CLK), .rst_n(NRST), .go(go), .addr(go_addr), .stall(FETCH_STALL),
		.fetch_valid(FETCH_VALID), .fetch_addr(FETCH_ADDR));
	// 4 ns core clock
	always #2 CORE_CLK = ~CORE_CLK;
	// ****************************
	// tasks
	// ****************************
	task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			fails++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	// report one branch, then update the model the same way
	task automatic res(logic [31:0] s, logic [31:0] e, fwbp_kind_type k, logic tk, logic [7:0] op, logic [1:0] fl);
		fwbp_ment_type m;
		int w, n;
		w = e[31:4];
		n = -1;
		m = '{e[3:0], $urandom, s[31:4] != e[31:4], op == 8'hc3 && fl != 0, k == BK_RET};
		@(posedge CORE_CLK);
		RES <= '{s, e, m.tgt, k, tk, op, 16'h0, k == BK_CALL && fl != 0, fl[1], fl[0]};
		RES_VALID <= 1'b1;
		@(posedge CORE_CLK);
		RES_VALID <= 1'b0;
		if (k == BK_CALL && fl == 0) ras.push_back(e + 1);
		if (ras.size() > 8) ras.pop_front();
		if (k == BK_RET && ras.size() > 0) ras.pop_back();
		if (tbl.exists(w)) foreach (tbl[w][i]) if (tbl[w][i].off == m.off) n = i;
		if (!tk || k == BK_FAR) return;
		if (n >= 0) tbl[w][n].tgt = m.tgt;
		else if (tbl[w].size() < 3) tbl[w].push_back(m);
		else tbl[w][2] = m;
	endtask
	// lookup through the fetch model and compare with the model
	task automatic look(logic [31:0] a);
		fwbp_ment_type m;
		int w, n;
		logic hit, tk;
		logic [31:0] nx;
		w = a[31:4];
		n = -1;
		m = '{0, 0, 0, 0, 0};
		if (tbl.exists(w)) foreach (tbl[w][i]) if (tbl[w][i].off >= a[3:0] && (n < 0 || tbl[w][i].off < m.off)) begin
			n = i;
			m = tbl[w][i];
		end
		hit = n >= 0 && !m.unp;
		tk = hit && !(m.ret && ras.size() == 0);
		nx = !tk ? (a | BLOCK_MASK) + 1 : m.ret ? ras[$] : m.tgt;
		@(posedge CORE_CLK);
		go <= 1'b1;
		go_addr <= a;
		@(posedge CORE_CLK);
		go <= 1'b0;
		for (n = 0; n < 20 && PRED.valid !== 1'b1; n++) begin
			@(posedge CORE_CLK);
			#1;
		end
		if (n == 20) begin
			chk("pred_valid", PRED.valid, 1'b1);
			end_of_test();
		end
		chk("hit", PRED.hit, hit);
		chk("taken", PRED.taken, tk);
		chk("solo", PRED.solo, tk && m.solo);
		chk("next_addr", PRED.next_addr, nx);
		chk("next_bytes", PRED.next_bytes, 32 - nx[4:0]);
		if (hit) chk("end_off", PRED.end_off, m.off);
		chk("stall", FETCH_STALL, tk);
	endtask
	// ****************************
	// main sequence
	// ****************************
	initial begin
		void'($urandom(32'heaed));
		repeat (5) @(posedge CORE_CLK);
		NRST <= 1'b1;
		repeat (3) @(posedge CORE_CLK);
		b = $urandom & 32'hfffff000;
		look(b + 5);
		$display("reset test done");
		res(b + 4, b + 5, BK_COND, 1'b0, 8'h74, 2'h0);
		look(b + 2);
		res(b + 9, b + 10, BK_JUMP, 1'b1, 8'heb, 2'h0);
		look(b + 2);
		// back to back: the second lookup meets the bubble and is re-presented
		@(posedge CORE_CLK);
		go <= 1'b1;
		go_addr <= b + 2;
		@(posedge CORE_CLK);
		go_addr <= b + 32'h12;
		@(posedge CORE_CLK);
		go <= 1'b0;
		#1;
		chk("first taken", PRED.taken, 1'b1);
		@(posedge CORE_CLK);
		#1;
		chk("refused valid", PRED.valid, 1'b0);
		@(posedge CORE_CLK);
		#1;
		chk("second valid", PRED.valid, 1'b1);
		chk("second next_addr", PRED.next_addr, b + 32'h20);
		$display("allocation test done");
		res(b + 32'h1e, b + 32'h21, BK_COND, 1'b1, 8'h0f, 2'h0);
		look(b + 32'h20);
		$display("straddle test done");
		for (int i = 1; i <= 4; i++) res(b + 3 * i + 32'h3f, b + 3 * i + 32'h40, BK_JUMP, 1'b1, 8'heb, 2'h0);
		for (int j = 0; j < 4; j++) look(b + 32'h40 + 3 * j + (j > 1));
		$display("full window test done");
		res(b + 32'h81, b + 32'h86, BK_FAR, 1'b1, 8'hea, 2'h0);
		look(b + 32'h80);
		for (int f = 0; f < 4; f++) begin
			res(b + 32'h100 * f + 32'h200, b + 32'h100 * f + 32'h204, BK_CALL, 1'b1, 8'he8, 2'h0);
			res(b + 32'h100 * f + 32'h205, b + 32'h100 * f + 32'h209, BK_CALL, 1'b1, 8'he8, 2'h0);
			res(b + 32'h100 * f + 32'h20c, b + 32'h100 * f + 32'h20c, BK_RET, 1'b1, 8'hc3, f[1:0]);
			look(b + 32'h100 * f + 32'h20a);
		end
		res(b + 32'h600, b + 32'h602, BK_RET, 1'b1, 8'hc2, 2'h3);
		look(b + 32'h600);
		$display("return test done");
		// ten calls overflow the stack; returns then drain only the newest eight
		for (int i = 0; i < 10; i++) begin
			res(b + 32'h800 + 16 * i, b + 32'h804 + 16 * i, BK_CALL, 1'b1, 8'he8, 2'h0);
		end
		for (int i = 0; i < 9; i++) begin
			res(b + 32'h900 + 16 * i, b + 32'h902 + 16 * i, BK_RET, 1'b1, 8'hc2, 2'h0);
			look(b + 32'h900 + 16 * i);
		end
		// a zero-displacement call must not push
		res(b + 32'ha00, b + 32'ha04, BK_CALL, 1'b1, 8'he8, 2'h0);
		res(b + 32'ha05, b + 32'ha08, BK_CALL, 1'b1, 8'he8, 2'h0);
		res(b + 32'ha09, b + 32'ha0c, BK_CALL, 1'b1, 8'he8, 2'h1);
		res(b + 32'ha10, b + 32'ha12, BK_RET, 1'b1, 8'hc2, 2'h0);
		look(b + 32'ha10);
		$display("stack test done");
		end_of_test();
	end
endmodule
`default_nettype wire
